//--- hw/msc_regs.v
// Memory size configuration register bank on the CPU byte bus.
// Assumes single-cycle 8-bit CPU memory accesses on CLK_SYS.
// Behaviour
// - Reset loads the memory size register with cf.
// - The memory size register is read and written as one byte; bit 4 is not stored and reads zero.
// - High-speed RAM code 000 means 768 bytes, 110 means 1024, others are prohibited.
// - Reset loads the expansion RAM size register with 0c.
// - The expansion RAM size register is read and written as one byte.
// - Expansion codes 01100/01010/01000/00100/00000 mean 0/1K/2K/4K/6K bytes.
`timescale 1ns/100ps
`include "msc_defs.vh"

module msc_regs (
  CLK_SYS,       // System clock, 50 MHz
  SYS_RST,       // Synchronous reset, active high
  BUS_ADDR,      // CPU memory address
  BUS_WR,        // Write strobe, one cycle
  BUS_RD,        // Read strobe, one cycle
  BUS_WDATA,     // Write byte
  BUS_RDATA,     // Read byte, registered
  BUS_HIT,       // Address hits a size register
  HS_RAM_SIZE,   // High-speed RAM field
  ROM_SIZE,      // ROM field
  XRAM_SIZE,     // Expansion RAM field
  HS_RAM_BYTES,  // High-speed RAM bytes
  ROM_KB,        // ROM size in KB
  XRAM_BYTES,    // Expansion RAM bytes
  CFG_ILLEGAL    // Some field holds a prohibited code
);
  input wire CLK_SYS;
  input wire SYS_RST;
  input wire [`MSC_ADDR_W-1:0] BUS_ADDR;
  input wire BUS_WR;
  input wire BUS_RD;
  input wire [7:0] BUS_WDATA;
  output wire [7:0] BUS_RDATA;
  output wire BUS_HIT;
  output wire [2:0] HS_RAM_SIZE;
  output wire [3:0] ROM_SIZE;
  output wire [4:0] XRAM_SIZE;
  output wire [10:0] HS_RAM_BYTES;
  output wire [6:0] ROM_KB;
  output wire [12:0] XRAM_BYTES;
  output wire CFG_ILLEGAL;

  // ==========================================================
  // Register state and next values
  reg [7:0] memory_size_select_reg;
  reg [7:0] memory_size_select_next;
  reg [7:0] expansion_ram_size_select_reg;
  reg [7:0] expansion_ram_size_select_next;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg [10:0] hs_bytes_reg;
  reg [6:0] rom_kb_reg;
  reg [12:0] xram_bytes_reg;
  reg illegal_reg;

  // Decode results for the values the registers take next
  wire [2:0] hs_ram_size_field_next;
  wire [3:0] rom_size_field_next;
  wire [4:0] xram_size_field_next;
  wire [10:0] hs_bytes_next;
  wire [6:0] rom_kb_next;
  wire [12:0] xram_bytes_next;
  wire hs_ok_next;
  wire rom_ok_next;
  wire xram_ok_next;
  wire illegal_next;

  // Bus qualifiers
  wire sel_mem;
  wire sel_xram;
  wire wr_mem;
  wire wr_xram;

  // ==========================================================
  // Shared helpers
  // Full 16-bit compare; a partial decode would alias the two
  // registers onto neighbouring addresses in the top page
  function addr_match;
    input [`MSC_ADDR_W-1:0] addr;
    input [`MSC_ADDR_W-1:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // Byte merge for a write; bits outside the mask are dropped
  function [7:0] masked_byte;
    input [7:0] data;
    input [7:0] mask;
    begin
      masked_byte = data & mask;
    end
  endfunction

  // ==========================================================
  // Address decode
  assign sel_mem = addr_match(BUS_ADDR, `MSC_MEM_SIZE_ADDR);
  assign sel_xram = addr_match(BUS_ADDR, `MSC_XRAM_SIZE_ADDR);
  // Hit is combinational so the CPU side can steer its own read mux
  assign BUS_HIT = sel_mem | sel_xram;
  // Writes need the strobe; reset beats any write in the same cycle
  assign wr_mem = BUS_WR & sel_mem;
  assign wr_xram = BUS_WR & sel_xram;

  // ==========================================================
  // Memory size register
  // Next value; reset is folded in so every flop has one source
  // A write lands on the edge that samples the strobe
  always @* begin
    memory_size_select_next = memory_size_select_reg;
    if (SYS_RST) begin
      memory_size_select_next = `MSC_MEM_SIZE_RST;
    end else if (wr_mem) begin
      memory_size_select_next = masked_byte(BUS_WDATA, `MSC_MEM_SIZE_MASK);
    end
  end

  // State flop
  always @(posedge CLK_SYS) begin
    memory_size_select_reg <= memory_size_select_next;
  end

  // ==========================================================
  // Expansion RAM size register
  // Order against the memory size register is left to software
  always @* begin
    expansion_ram_size_select_next = expansion_ram_size_select_reg;
    if (SYS_RST) begin
      expansion_ram_size_select_next = `MSC_XRAM_SIZE_RST;
    end else if (wr_xram) begin
      expansion_ram_size_select_next = masked_byte(BUS_WDATA, `MSC_XRAM_SIZE_MASK);
    end
  end

  // State flop
  always @(posedge CLK_SYS) begin
    expansion_ram_size_select_reg <= expansion_ram_size_select_next;
  end

  // ==========================================================
  // Read path
  // Mux of the current contents; unmapped addresses read zero
  // A read in the same cycle as a write returns the old byte
  // Reset clears the held byte so no stale value shows after it
  always @* begin
    rdata_next = rdata_reg;
    if (SYS_RST) begin
      rdata_next = 8'h00;
    end else if (BUS_RD) begin
      rdata_next = 8'h00;
      if (sel_mem) begin
        rdata_next = memory_size_select_reg;
      end else if (sel_xram) begin
        rdata_next = expansion_ram_size_select_reg;
      end
    end
  end

  // Read byte held in a flop so it stays put after the strobe
  always @(posedge CLK_SYS) begin
    rdata_reg <= rdata_next;
  end

  assign BUS_RDATA = rdata_reg;

  // ==========================================================
  // Field outputs straight from the register flops
  // A prohibited code is shown as stored; the flag tells it apart
  assign HS_RAM_SIZE = memory_size_select_reg[`MSC_HS_RAM_MSB:`MSC_HS_RAM_LSB];
  assign ROM_SIZE = memory_size_select_reg[`MSC_ROM_MSB:`MSC_ROM_LSB];
  assign XRAM_SIZE = expansion_ram_size_select_reg[`MSC_XRAM_MSB:`MSC_XRAM_LSB];

  // ==========================================================
  // Size decode
  // Decoding the next values lets the sizes leave flops yet move
  // on the same edge as the fields, at the cost of a longer path
  // from the write data
  assign hs_ram_size_field_next = memory_size_select_next[`MSC_HS_RAM_MSB:`MSC_HS_RAM_LSB];
  assign rom_size_field_next = memory_size_select_next[`MSC_ROM_MSB:`MSC_ROM_LSB];
  assign xram_size_field_next = expansion_ram_size_select_next[`MSC_XRAM_MSB:`MSC_XRAM_LSB];

  msc_decode u_decode (
    .hs_code(hs_ram_size_field_next),
    .rom_code(rom_size_field_next),
    .xram_code(xram_size_field_next),
    .hs_bytes(hs_bytes_next),
    .rom_kb(rom_kb_next),
    .xram_bytes(xram_bytes_next),
    .hs_ok(hs_ok_next),
    .rom_ok(rom_ok_next),
    .xram_ok(xram_ok_next)
  );

  // Flag only; prohibited codes are stored as written, not blocked
  assign illegal_next = ~(hs_ok_next & rom_ok_next & xram_ok_next);

  // Decoded sizes and flag held in flops
  // Reset codes decode as legal, so the flag is low after reset
  always @(posedge CLK_SYS) begin
    hs_bytes_reg <= hs_bytes_next;
    rom_kb_reg <= rom_kb_next;
    xram_bytes_reg <= xram_bytes_next;
    illegal_reg <= illegal_next;
  end

  assign HS_RAM_BYTES = hs_bytes_reg;
  assign ROM_KB = rom_kb_reg;
  assign XRAM_BYTES = xram_bytes_reg;
  assign CFG_ILLEGAL = illegal_reg;
endmodule

//--- hw/msc_defs.vh
// Constants for the memory size configuration register bank.
// Assumes inclusion by bare name from the design files.
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// ==========================================================
// Register addresses on the CPU memory space
`define MSC_ADDR_W 16
`define MSC_MEM_SIZE_ADDR 16'hfff0
`define MSC_XRAM_SIZE_ADDR 16'hfff4

// ==========================================================
// Reset values
`define MSC_MEM_SIZE_RST 8'hcf
`define MSC_XRAM_SIZE_RST 8'h0c

// ==========================================================
// Field positions and writable masks
`define MSC_HS_RAM_MSB 7
`define MSC_HS_RAM_LSB 5
`define MSC_ROM_MSB 3
`define MSC_ROM_LSB 0
`define MSC_XRAM_MSB 4
`define MSC_XRAM_LSB 0
`define MSC_MEM_SIZE_MASK 8'hef
`define MSC_XRAM_SIZE_MASK 8'h1f

// ==========================================================
// Field codes
`define MSC_HS_RAM_768 3'h0
`define MSC_HS_RAM_1024 3'h6
`define MSC_ROM_16K 4'h4
`define MSC_ROM_24K 4'h6
`define MSC_ROM_32K 4'h8
`define MSC_ROM_48K 4'hc
`define MSC_ROM_60K 4'hf
`define MSC_XRAM_0 5'h0c
`define MSC_XRAM_1K 5'h0a
`define MSC_XRAM_2K 5'h08
`define MSC_XRAM_4K 5'h04
`define MSC_XRAM_6K 5'h00

`endif

//--- hw/msc_decode.v
// Decoder from size field codes to byte and KB sizes and legality flags.
// Assumes the codes come from the next values of the size registers.
`timescale 1ns/100ps
`include "msc_defs.vh"

module msc_decode (
  hs_code,    // High-speed RAM field
  rom_code,   // ROM field
  xram_code,  // Expansion RAM field
  hs_bytes,   // High-speed RAM bytes
  rom_kb,     // ROM size in KB
  xram_bytes, // Expansion RAM bytes
  hs_ok,      // HS code legal
  rom_ok,     // ROM code legal
  xram_ok     // XRAM code legal
);
  input wire [2:0] hs_code;
  input wire [3:0] rom_code;
  input wire [4:0] xram_code;
  output reg [10:0] hs_bytes;
  output reg [6:0] rom_kb;
  output reg [12:0] xram_bytes;
  output reg hs_ok;
  output reg rom_ok;
  output reg xram_ok;

  // ==========================================================
  // Code tables
  // high-speed RAM codes
  always @* begin
    hs_ok = 1'b1;
    case (hs_code)
      `MSC_HS_RAM_768: hs_bytes = 11'd768;
      `MSC_HS_RAM_1024: hs_bytes = 11'd1024;
      default: begin
        hs_bytes = 11'd0;
        hs_ok = 1'b0;
      end
    endcase
  end

  always @* begin
    rom_ok = 1'b1;
    case (rom_code)
      `MSC_ROM_16K: rom_kb = 7'd16;
      `MSC_ROM_24K: rom_kb = 7'd24;
      `MSC_ROM_32K: rom_kb = 7'd32;
      `MSC_ROM_48K: rom_kb = 7'd48;
      `MSC_ROM_60K: rom_kb = 7'd60;
      default: begin
        rom_kb = 7'd0;
        rom_ok = 1'b0;
      end
    endcase
  end

  always @* begin
    xram_ok = 1'b1;
    case (xram_code)
      `MSC_XRAM_0: xram_bytes = 13'd0;
      `MSC_XRAM_1K: xram_bytes = 13'd1024;
      `MSC_XRAM_2K: xram_bytes = 13'd2048;
      `MSC_XRAM_4K: xram_bytes = 13'd4096;
      `MSC_XRAM_6K: xram_bytes = 13'd6144;
      default: begin
        xram_bytes = 13'd0;
        xram_ok = 1'b0;
      end
    endcase
  end
endmodule

//--- dv/msc_regs_checker.sv
// Assertions bound onto msc_regs.
// Assumes only the ports of msc_regs are visible.
`timescale 1ns/100ps
module msc_regs_checker (
  input wire CLK_SYS, // Clock
  input wire SYS_RST, // Reset
  input wire [15:0] BUS_ADDR, // Address
  input wire BUS_WR, // Write
  input wire BUS_RD, // Read
  input wire [7:0] BUS_WDATA, // Byte in
  input wire [7:0] BUS_RDATA, // Byte out
  input wire BUS_HIT, // Hit
  input wire [2:0] HS_RAM_SIZE, // Field
  input wire [3:0] ROM_SIZE, // Field
  input wire [4:0] XRAM_SIZE // Field
);
  // ====
  // Bus side; bit 4 of the memory byte always reads zero
  wire [7:0] mem_v = {HS_RAM_SIZE, 1'b0, ROM_SIZE};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence wr_mem; BUS_WR && BUS_ADDR == 16'hfff0; endsequence
  sequence rd_mem; BUS_RD && BUS_ADDR == 16'hfff0; endsequence
  chk_mem_wr: assert property (wr_mem |=> mem_v == ($past(BUS_WDATA) & 8'hef))
    else $error("mem write");
  chk_xram_wr: assert property (
    BUS_WR && BUS_ADDR == 16'hfff4 |=> XRAM_SIZE == $past(BUS_WDATA[4:0])) else $error("xwr");
  chk_mem_rd: assert property (rd_mem |=> BUS_RDATA == $past(mem_v)) else $error("rd");
  chk_xram_rd: assert property (
    BUS_RD && BUS_ADDR == 16'hfff4 |=> BUS_RDATA == {3'h0, $past(XRAM_SIZE)}) else $error("xrd");
  chk_miss_rd: assert property (
    BUS_RD && BUS_ADDR != 16'hfff0 && BUS_ADDR != 16'hfff4 |=> !BUS_RDATA) else $error("miss");
  chk_rd_hold: assert property (!BUS_RD |=> $stable(BUS_RDATA)) else $error("rd hold");
  chk_reg_hold: assert property (
    !BUS_WR |=> $stable({mem_v, XRAM_SIZE})) else $error("reg hold");
  chk_bus_hit: assert property (
    BUS_HIT == (BUS_ADDR == 16'hfff0 || BUS_ADDR == 16'hfff4)) else $error("hit");
  chk_reset_load: assert property (
    $fell(SYS_RST) |-> mem_v == 8'hcf && XRAM_SIZE == 5'h0c) else $error("reset value");
endmodule
bind msc_regs msc_regs_checker msc_regs_checker_inst (.CLK_SYS, .SYS_RST, .BUS_ADDR, .BUS_WR,
  .BUS_RD, .BUS_WDATA, .BUS_RDATA, .BUS_HIT, .HS_RAM_SIZE, .ROM_SIZE, .XRAM_SIZE);

//--- dv/memory_size_config_regs_test.sv
// Bench for the size register bank against an integer model.
// Assumes msc_regs and its checker are compiled first.
`timescale 1ns/100ps
module memory_size_config_regs_test;
  reg clk = 0, rst = 1, wr = 0, rd = 0;
  reg [15:0] ad = 0;
  reg [7:0] wd = 0;
  wire [7:0] rq;
  wire [10:0] hb;
  wire [6:0] rk;
  wire [12:0] xb;
  wire bad;
  integer error_cnt = 0, compares = 0, cyc = 0, i, a, h, k, b, mm, xm;
  msc_regs msc_regs_inst (.CLK_SYS(clk), .SYS_RST(rst), .BUS_ADDR(ad), .BUS_WR(wr), .BUS_RD(rd),
    .BUS_WDATA(wd), .BUS_RDATA(rq), .BUS_HIT(), .HS_RAM_SIZE(), .ROM_SIZE(), .XRAM_SIZE(),
    .HS_RAM_BYTES(hb), .ROM_KB(rk), .XRAM_BYTES(xb), .CFG_ILLEGAL(bad));
  // ====
  // Clock; the guard sits far above the run length
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) report_and_stop(1);
  task cmp(input string n, input integer e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask
  // Reset for n cycles, model back to reset values
  task do_rst(input integer n);
    @(posedge clk);
    rst <= 1;
    repeat (n) @(posedge clk);
    rst <= 0;
    mm = 8'hcf;
    xm = 8'h0c;
  endtask
  // One access; every access also checks the decoded sizes
  task acc(input w, input [15:0] an, input [7:0] d);
    @(posedge clk);
    {ad, wd, wr, rd} <= {an, d, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    if (w && an == 16'hfff0) mm = d & 8'hef;
    if (w && an == 16'hfff4) xm = d & 8'h1f;
    #1;
    h = mm >> 5 == 0 ? 768 : mm >> 5 == 6 ? 1024 : 0;
    k = mm % 16;
    k = k == 4 ? 16 : k == 6 ? 24 : k == 8 ? 32 : k == 12 ? 48 : k == 15 ? 60 : 0;
    b = xm == 12 ? 0 : xm == 10 ? 1024 : xm == 8 ? 2048 : xm == 4 ? 4096 : xm ? -1 : 6144;
    if (!w) cmp("rdata", an == 16'hfff0 ? mm : an == 16'hfff4 ? xm : 0, rq);
    cmp("hs_bytes", h, hb);
    cmp("rom_kb", k, rk);
    cmp("xram_bytes", b < 0 ? 0 : b, xb);
    cmp("illegal", !h || !k || b < 0, bad);
  endtask
  initial begin
    a = $urandom(18070);
    do_rst(7);
    acc(0, 16'hfff0, 8'h00);
    acc(0, 16'hfff4, 8'h00);
    $display("reset test done");
    // memory size first; product pairs keep ROM and expansion RAM apart
    for (i = 0; i < 7; i = i + 1) begin
      acc(1, 16'hfff0, 8'(56'h04c6c8cccfcccc >> 48 - 8 * i) | 8'h10);
      acc(1, 16'hfff4, 8'(56'h0c0c0c0a080400 >> 48 - 8 * i) | 8'he0);
    end
    $display("legal code test done");
    for (i = 0; i < 40; i = i + 1) begin
      a = 16'hfff0 + $urandom % 3 * 4;
      acc(1, a[15:0], 8'($urandom));
      acc(0, a[15:0], 8'h00);
    end
    $display("random test done");
    do_rst(1);
    acc(0, 16'hfff4, 8'h00);
    $display("second reset test done");
    report_and_stop(0);
  end
  task report_and_stop(input integer extra);
    error_cnt = error_cnt + extra;
    $display("%0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
endmodule
